/* logic/lps_pkg.sv */
// Constants, types and helpers of the low-power state sequencer.
// Assumes one 25 MHz system clock and a plain register port.
package lps_pkg;

  // Clock
  localparam int unsigned CLK_HZ = 25_000_000;

  // Register port geometry
  localparam int AW = 3;
  localparam int DW = 8;
  localparam int BAUD_W = 3;

  // Register indices
  localparam logic [AW-1:0] ADDR_OPMODE = 3'h0;
  localparam logic [AW-1:0] ADDR_ACK_EN = 3'h1;
  localparam logic [AW-1:0] ADDR_BAUD = 3'h2;
  localparam logic [AW-1:0] ADDR_NV_BAUD = 3'h3;
  localparam logic [AW-1:0] ADDR_NV_ACK = 3'h4;
  localparam logic [AW-1:0] ADDR_STATUS = 3'h5;

  // Operating mode codes
  localparam logic [DW-1:0] MODE_ACTIVE = 8'h00;
  localparam logic [DW-1:0] MODE_SLEEP = 8'h01;
  localparam logic [DW-1:0] MODE_STANDBY = 8'h02;
  localparam logic [DW-1:0] MODE_DEEP = 8'h03;

  // Wake acknowledge byte
  localparam logic [7:0] ACK_BYTE = 8'h06;

  // Non-volatile word indices and factory defaults
  localparam int NV_AW = 1;
  localparam logic [NV_AW-1:0] NV_IDX_BAUD = 1'h0;
  localparam logic [NV_AW-1:0] NV_IDX_ACK = 1'h1;
  localparam logic [DW-1:0] BAUD_DEFAULT = 8'h02;
  localparam logic [DW-1:0] ACK_DEFAULT = 8'h00;

  // Status bit positions
  localparam int ST_REINIT_BIT = 0;
  localparam int ST_LP_BIT = 1;
  localparam int ST_ARMED_BIT = 2;

  // Controller clock select codes
  localparam logic [1:0] CLK_FULL = 2'h0;
  localparam logic [1:0] CLK_SLOW = 2'h1;
  localparam logic [1:0] CLK_STOP = 2'h2;

  // Timing
  localparam int unsigned WAKE_MAX_MS = 6;
  localparam int unsigned WAKE_SETTLE_US = 100;
  localparam logic [15:0] WAKE_SETTLE_CYC = 16'(WAKE_SETTLE_US * (CLK_HZ / 1_000_000));
  localparam logic [15:0] BOOT_SETTLE_CYC = 16'h0003;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_BOOT, ST_CFG_HOLD, ST_RESTORE, ST_LOAD, ST_ACTIVE,
    ST_LP, ST_ARMED, ST_WAKE, ST_ACK
  } lps_state_t;

  // Baud rate of a setting code
  function automatic int unsigned baud_rate(input logic [BAUD_W-1:0] s);
    unique case (s)
      3'h0: baud_rate = 2400;
      3'h1: baud_rate = 4800;
      3'h2: baud_rate = 9600;
      3'h3: baud_rate = 19200;
      3'h4: baud_rate = 31250;
      3'h5: baud_rate = 38400;
      3'h6: baud_rate = 57600;
      default: baud_rate = 115200;
    endcase
  endfunction : baud_rate

  // Clock cycles in one bit-time
  function automatic logic [15:0] bit_cycles(input logic [BAUD_W-1:0] s);
    bit_cycles = 16'(CLK_HZ / baud_rate(s));
  endfunction : bit_cycles

endpackage : lps_pkg

/* logic/lps_nvmem.sv */
// Small non-volatile word store with a registered read port.
// Assumes one writer or reader per cycle; reset models a fresh part.
`timescale 1ns/1ns
module lps_nvmem
  import lps_pkg::*;
#(
  parameter int WIDTH = DW,
  parameter int DEPTH = 2
)(
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  // Access port
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  output logic      [WIDTH-1:0]         rd_data
);
  initial
  begin
    if (DEPTH < 2 || WIDTH < BAUD_W) $error("lps_nvmem: DEPTH or WIDTH too small");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];  // Stored words

  // Write and registered read; reset loads factory content
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= (i == 0) ? BAUD_DEFAULT : ACK_DEFAULT;
      rd_data <= '0;
    end
    else if (clk_en)
    begin
      if (wr_en) mem_q[addr] <= wr_data;
      rd_data <= mem_q[addr];
    end
  end
endmodule : lps_nvmem

/* logic/lps_ctrl.sv */
// Low-power state sequencer: mode entry, wake, pin parking, setting reload.
// Assumes pins arrive unsynchronised and core signals share sys_clk.
`timescale 1ns/1ns
module lps_ctrl (
  // Clock, reset, enable
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire logic                     clk_en,
  // Register port
  input  wire logic [lps_pkg::AW-1:0]   reg_addr,
  input  wire logic [lps_pkg::DW-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [lps_pkg::DW-1:0]   reg_rdata,
  // Pins from the host
  input  wire logic                     rxd_pin,
  input  wire logic                     reset_line_pin,
  input  wire logic                     config_line_n_pin,
  // Core side, same clock
  input  wire logic                     ram_ok,
  input  wire logic                     core_txd,
  input  wire logic                     core_cts_n,
  input  wire logic                     core_pkt,
  input  wire logic                     core_exc,
  input  wire logic                     core_rssi,
  input  wire logic                     core_cmd_reply,
  input  wire logic                     core_buf_empty,
  input  wire logic                     core_debug_oe_n,
  // Pins to the host
  output logic                          txd_o,
  output logic                          txd_oe_n,
  output logic                          cts_n_o,
  output logic                          packet_processing_output,
  output logic                          exception_output,
  output logic                          rssi_o,
  output logic                          command_reply_line_o,
  output logic                          command_reply_line_oe_n,
  output logic                          buffer_empty_line_o,
  output logic                          buffer_empty_line_oe_n,
  output logic                          debug_data_pin_oe_n,
  output logic                          pullup_en_o,
  // Radio and controller power
  output logic                          radio_tx_en_o,
  output logic                          radio_rx_en_o,
  output logic                          radio_osc_en_o,
  output logic                          radio_lowest_o,
  output logic                          hop_sync_en_o,
  output logic                          rx_monitor_en_o,
  output logic      [1:0]               ctl_clk_sel_o,
  output logic                          nonessential_en_o,
  output logic                          core_run_o
);
  import lps_pkg::*;

  // Pin synchronisers, idle high like the pull-ups
  logic rxd_m, rxd_s, rstl_m, rstl_s, cfg_m, cfg_s;

  // Control state
  lps_state_t        state_q, state_d;  // Sequencer
  logic [DW-1:0]     mode_q, mode_d;    // operating_mode_select
  logic              ack_en_q, ack_en_d;  // wake_acknowledge_enable
  logic [BAUD_W-1:0] baud_q, baud_d;    // active_baud_setting
  logic [DW-1:0]     nvb_q, nvb_d;      // stored_baud_setting shadow
  logic [DW-1:0]     nva_q, nva_d;      // Stored ack enable shadow
  logic              reinit_q, reinit_d;  // Sticky re-init seen
  logic [15:0]       cnt_q, cnt_d;      // Shared cycle counter
  logic [3:0]        bit_q, bit_d;      // Ack bit index
  logic [9:0]        shf_q, shf_d;      // Ack frame shifter
  logic [1:0]        ld_q, ld_d;        // Reload/restore step
  logic [DW-1:0]     rdat_d;            // Read data next value
  logic              start_ack;         // Launch the ack frame

  // Memory port
  logic              mem_we;
  logic [NV_AW-1:0]  mem_addr;
  logic [DW-1:0]     mem_wdata, mem_rdata;

  // Bit-time of the active setting
  logic [15:0] bitcyc;
  assign bitcyc = bit_cycles(baud_q);

  // Sequencing owns the memory; stored-setting writes then drop
  logic seq_busy;
  assign seq_busy = (state_q == ST_RESTORE) || (state_q == ST_LOAD);

  // Two-flop synchronisers for the asynchronous pins
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {rxd_m, rxd_s, rstl_m, rstl_s, cfg_m, cfg_s} <= 6'h3F;
    end
    else if (clk_en)
    begin
      {rxd_m, rstl_m, cfg_m} <= {rxd_pin, reset_line_pin, config_line_n_pin};
      {rxd_s, rstl_s, cfg_s} <= {rxd_m, rstl_m, cfg_m};
    end
  end

  // Stored settings; shadows serve register reads in one cycle
  lps_nvmem #(
    .WIDTH (DW),
    .DEPTH (2)
  ) u_nvmem (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .wr_en   (mem_we),
    .addr    (mem_addr),
    .wr_data (mem_wdata),
    .rd_data (mem_rdata)
  );

  // Next state: register writes first, sequencer after so its sets win
  always_comb
  begin
    {state_d, mode_d, ack_en_d, baud_d} = {state_q, mode_q, ack_en_q, baud_q};
    {nvb_d, nva_d, reinit_d} = {nvb_q, nva_q, reinit_q};
    {cnt_d, bit_d, shf_d, ld_d} = {cnt_q, bit_q, shf_q, ld_q};
    mem_we = 1'b0;
    mem_addr = NV_IDX_BAUD;
    mem_wdata = reg_wdata;
    start_ack = 1'b0;
    rdat_d = '0;
    // Register reads
    if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_OPMODE:  rdat_d = mode_q;
        ADDR_ACK_EN:  rdat_d = {7'h00, ack_en_q};
        ADDR_BAUD:    rdat_d = {5'h00, baud_q};
        ADDR_NV_BAUD: rdat_d = nvb_q;
        ADDR_NV_ACK:  rdat_d = nva_q;
        ADDR_STATUS:  rdat_d = {5'h00, state_q == ST_ARMED, state_q == ST_LP, reinit_q};
        default:      rdat_d = '0;  // Unmapped reads zero
      endcase
    end
    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_OPMODE:
        begin
          // Only legal codes, only while running
          if (state_q == ST_ACTIVE && (reg_wdata == MODE_SLEEP ||
              reg_wdata == MODE_STANDBY || reg_wdata == MODE_DEEP))
            mode_d = reg_wdata;
        end
        ADDR_ACK_EN: ack_en_d = reg_wdata[0];
        ADDR_BAUD:   baud_d = reg_wdata[BAUD_W-1:0];
        ADDR_NV_BAUD:
        begin
          if (!seq_busy)
          begin
            mem_we = 1'b1;
            nvb_d = reg_wdata;
          end
        end
        ADDR_NV_ACK:
        begin
          if (!seq_busy)
          begin
            mem_we = 1'b1;
            mem_addr = NV_IDX_ACK;
            nva_d = reg_wdata;
          end
        end
        ADDR_STATUS: reinit_d = 1'b0;  // Any write clears the sticky bit
        default: ;
      endcase
    end
    // Sequencer
    unique case (state_q)
      ST_BOOT:
      begin
        // Let the synchronisers fill before looking at the config line
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == BOOT_SETTLE_CYC - 16'h0001)
        begin
          cnt_d = '0;
          ld_d = '0;
          state_d = cfg_s ? ST_LOAD : ST_CFG_HOLD;
        end
      end
      ST_CFG_HOLD:
      begin
        if (cfg_s) state_d = ST_RESTORE;
      end
      ST_RESTORE:
      begin
        // Overwrite every stored word with its factory value
        mem_we = 1'b1;
        mem_addr = ld_q[0];
        mem_wdata = ld_q[0] ? ACK_DEFAULT : BAUD_DEFAULT;
        if (ld_q[0]) nva_d = ACK_DEFAULT;
        else nvb_d = BAUD_DEFAULT;
        ld_d = ld_q + 2'h1;
        if (ld_q == 2'h1)
        begin
          ld_d = '0;
          state_d = ST_LOAD;
        end
      end
      ST_LOAD:
      begin
        // Read baud, then ack; data arrive one cycle after the address
        mem_addr = (ld_q == 2'h0) ? NV_IDX_BAUD : NV_IDX_ACK;
        ld_d = ld_q + 2'h1;
        if (ld_q == 2'h1) baud_d = mem_rdata[BAUD_W-1:0];
        if (ld_q == 2'h2)
        begin
          ack_en_d = mem_rdata[0];
          mode_d = MODE_ACTIVE;
          ld_d = '0;
          if (mem_rdata[0]) start_ack = 1'b1;
          else state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE:
      begin
        if (mode_q != MODE_ACTIVE)
        begin
          cnt_d = '0;
          state_d = ST_LP;
        end
      end
      ST_LP:
      begin
        if (mode_q == MODE_DEEP)
        begin
          if (!rstl_s) state_d = ST_ARMED;
        end
        else if (!rxd_s)
        begin
          // Receive line must stay low one full bit-time
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q >= bitcyc - 16'h0001)
          begin
            cnt_d = '0;
            state_d = ST_WAKE;
          end
        end
        else cnt_d = '0;
      end
      ST_ARMED:
      begin
        // Waking started, but nothing runs until the line is high again
        if (rstl_s)
        begin
          cnt_d = '0;
          state_d = ST_WAKE;
        end
      end
      ST_WAKE:
      begin
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == WAKE_SETTLE_CYC - 16'h0001)
        begin
          // Settle time is far inside the wake budget
          cnt_d = '0;
          mode_d = MODE_ACTIVE;
          if (!ram_ok)
          begin
            reinit_d = 1'b1;
            ld_d = '0;
            state_d = ST_LOAD;
          end
          else if (ack_en_q) start_ack = 1'b1;
          else state_d = ST_ACTIVE;
        end
      end
      ST_ACK:
      begin
        // One 8N1 frame, LSB first, at the active rate
        cnt_d = cnt_q + 16'h0001;
        if (cnt_q == bitcyc - 16'h0001)
        begin
          cnt_d = '0;
          shf_d = {1'b1, shf_q[9:1]};
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h9)
          begin
            bit_d = '0;
            state_d = ST_ACTIVE;
          end
        end
      end
      default: state_d = ST_BOOT;
    endcase
    if (start_ack)
    begin
      cnt_d = '0;
      bit_d = '0;
      shf_d = {1'b1, ACK_BYTE, 1'b0};
      state_d = ST_ACK;
    end
  end

  // Control registers
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= ST_BOOT;
      mode_q <= MODE_ACTIVE;
      ack_en_q <= ACK_DEFAULT[0];
      baud_q <= BAUD_DEFAULT[BAUD_W-1:0];
      nvb_q <= BAUD_DEFAULT;
      nva_q <= ACK_DEFAULT;
      reinit_q <= 1'b0;
      cnt_q <= '0;
      bit_q <= '0;
      shf_q <= 10'h3FF;
      ld_q <= '0;
      reg_rdata <= '0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      ack_en_q <= ack_en_d;
      baud_q <= baud_d;
      nvb_q <= nvb_d;
      nva_q <= nva_d;
      reinit_q <= reinit_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      ld_q <= ld_d;
      reg_rdata <= rdat_d;
    end
  end

  // Pin and power outputs, next values
  logic [25:0] out_d, out_q;
  logic        lp_pins, deep, run;
  always_comb
  begin
    lp_pins = (state_q == ST_LP) || (state_q == ST_ARMED) || (state_q == ST_WAKE);
    deep = (mode_q == MODE_DEEP);
    run = (state_q == ST_ACTIVE);
    // Order: txd,txd_oe_n,cts_n,pkt,exc,rssi,cr,cr_oe_n,be,be_oe_n,dbg_oe_n,pu,
    //        tx,rx,osc,lowest,sync,mon,clk[1:0],nonessential,run, pad[3:0]
    out_d = {(state_q == ST_ACK) ? shf_q[0] : (run ? core_txd : 1'b1), 1'b0,
             run ? core_cts_n : 1'b1,
             run & core_pkt, run & core_exc, run & core_rssi,
             core_cmd_reply, 1'b0, core_buf_empty, 1'b0, core_debug_oe_n, 1'b0,
             6'h3B, CLK_FULL, 1'b1, run, 4'h0};
    if (lp_pins)
    begin
      // Pull-ups hold undriven lines; strength-type outputs forced low
      out_d[25:14] = {1'b1, 1'b1, deep, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
      if (mode_q == MODE_STANDBY)
        out_d[13:4] = {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, CLK_SLOW, 1'b1, 1'b0};
      else if (deep)
        out_d[13:4] = {1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, CLK_STOP, 1'b0, 1'b0};
      else
        out_d[13:4] = {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, CLK_SLOW, 1'b1, 1'b0};
    end
  end

  // Output flops; reset parks lines as in low power, strength pins low, radio off
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n) out_q <= 26'h38F_C000;
    else if (clk_en) out_q <= out_d;
  end

  assign {txd_o, txd_oe_n, cts_n_o, packet_processing_output, exception_output, rssi_o,
          command_reply_line_o, command_reply_line_oe_n, buffer_empty_line_o,
          buffer_empty_line_oe_n, debug_data_pin_oe_n, pullup_en_o, radio_tx_en_o,
          radio_rx_en_o, radio_osc_en_o, radio_lowest_o, hop_sync_en_o, rx_monitor_en_o,
          ctl_clk_sel_o, nonessential_en_o, core_run_o} = out_q[25:4];
endmodule : lps_ctrl

/* tb/lps_chk.sv */
// Port-level assertions of the low-power sequencer.
// Assumes it is bound onto lps_ctrl; one clock, async active-low reset.
`timescale 1ns/1ns
module lps_chk
  import lps_pkg::*;
(
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rst_n,
  // Register port
  input wire logic [lps_pkg::AW-1:0] reg_addr,
  input wire logic [lps_pkg::DW-1:0] reg_wdata,
  input wire logic                   reg_wr,
  // Host control line
  input wire logic                   reset_line_pin,
  // Host pins
  input wire logic                   cts_n_o,
  input wire logic                   packet_processing_output,
  input wire logic                   exception_output,
  input wire logic                   rssi_o,
  input wire logic                   command_reply_line_oe_n,
  input wire logic                   buffer_empty_line_oe_n,
  input wire logic                   debug_data_pin_oe_n,
  input wire logic                   pullup_en_o,
  // Power controls
  input wire logic                   radio_tx_en_o,
  input wire logic                   radio_rx_en_o,
  input wire logic                   radio_osc_en_o,
  input wire logic                   radio_lowest_o,
  input wire logic                   hop_sync_en_o,
  input wire logic                   rx_monitor_en_o,
  input wire logic [1:0]             ctl_clk_sel_o,
  input wire logic                   nonessential_en_o,
  input wire logic                   core_run_o
);
  // Single domain, so clock and disable are given once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Deep request while active parks within four cycles
  property p_deep_in;
    reg_wr && reg_addr == ADDR_OPMODE && reg_wdata == MODE_DEEP && core_run_o
      |-> ##[1:4] (ctl_clk_sel_o == CLK_STOP && cts_n_o);
  endproperty
  a_deep_in: assert property (p_deep_in) else $error("deep entry late");
  // Parked pins while pull-ups are on
  property p_park;
    pullup_en_o |-> !packet_processing_output && !exception_output && !rssi_o
      && command_reply_line_oe_n && buffer_empty_line_oe_n && debug_data_pin_oe_n;
  endproperty
  a_park: assert property (p_park) else $error("pins not parked");
  // Oscillator off in low power means every radio service off
  property p_radio_off;
    pullup_en_o && !radio_osc_en_o
      |-> !radio_tx_en_o && !radio_rx_en_o && !hop_sync_en_o && !rx_monitor_en_o;
  endproperty
  a_radio_off: assert property (p_radio_off) else $error("radio left on");
  // Slow controller clock keeps transmitter and receiver down
  property p_slow;
    pullup_en_o && ctl_clk_sel_o == CLK_SLOW |-> !radio_tx_en_o && !radio_rx_en_o;
  endproperty
  a_slow: assert property (p_slow) else $error("tx or rx on while slow");
  // Standby and sleep keep the host sending allowed
  property p_slow_cts;
    pullup_en_o && ctl_clk_sel_o == CLK_SLOW |-> !cts_n_o;
  endproperty
  a_slow_cts: assert property (p_slow_cts) else $error("cts high in light sleep");
  // Stopped clock only in deep: radio lowest, extras off, cts high
  property p_stop;
    ctl_clk_sel_o == CLK_STOP |-> radio_lowest_o && !nonessential_en_o && cts_n_o;
  endproperty
  a_stop: assert property (p_stop) else $error("deep state incomplete");
  // No wake while the reset line is still held low
  property p_deep_hold;
    radio_lowest_o && !reset_line_pin |=> !core_run_o;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("woke during hold");
  // Active operation has pins and clock restored
  property p_active;
    core_run_o |-> !pullup_en_o && ctl_clk_sel_o == CLK_FULL;
  endproperty
  a_active: assert property (p_active) else $error("active with parked pins");
endmodule : lps_chk

bind lps_ctrl lps_chk lps_chk_i (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reset_line_pin, .cts_n_o,
  .packet_processing_output, .exception_output, .rssi_o, .command_reply_line_oe_n,
  .buffer_empty_line_oe_n, .debug_data_pin_oe_n, .pullup_en_o, .radio_tx_en_o, .radio_rx_en_o,
  .radio_osc_en_o, .radio_lowest_o, .hop_sync_en_o, .rx_monitor_en_o, .ctl_clk_sel_o,
  .nonessential_en_o, .core_run_o
);

/* tb/lps_host.sv */
// Host model: drives receive, reset and config lines, listens on transmit.
// Assumes the bench resolves the transmit wire with its pull-up.
`timescale 1ns/1ns
module lps_host #(
  parameter int BIT_CYC = 217
)(
  // Clock
  input  wire logic sys_clk,
  // Resolved transmit wire
  input  wire logic txd_w,
  // Lines to the device, idle high as their pull-ups leave them
  output logic      rxd_pin,
  output logic      reset_line_pin,
  output logic      config_line_n_pin
);
  // Idle levels from time zero
  initial
  begin
    rxd_pin           = 1'b1;
    reset_line_pin    = 1'b1;
    config_line_n_pin = 1'b1;
  end

  // Hold one line low for n cycles, sel 0 receive, 1 reset
  task automatic pull(input int sel, input int n);
    @(posedge sys_clk);
    if (sel == 0)
      rxd_pin <= 1'b0; // Longer than a bit-time
    else
      reset_line_pin <= 1'b0; // Deep is the preferred mode, held 20 us
    repeat (n) @(posedge sys_clk);
    rxd_pin        <= 1'b1;
    reset_line_pin <= 1'b1;
  endtask : pull

  // Config line level; the hold time is scaled down in simulation
  task automatic cfg(input logic v);
    @(posedge sys_clk);
    config_line_n_pin <= v;
  endtask : cfg

  // Receive one byte, LSB first, sampled mid-bit
  task automatic recv(output logic [7:0] b, output logic s);
    int k;
    k = 0;
    while (txd_w !== 1'b0 && k < 4000)
    begin
      @(posedge sys_clk);
      k++;
    end
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BIT_CYC) @(posedge sys_clk);
      b[i] = txd_w;
    end
    repeat (BIT_CYC) @(posedge sys_clk);
    s = txd_w;
  endtask : recv
endmodule : lps_host

/* tb/tb_lps_ctrl.sv */
// Self-checking bench of the low-power sequencer.
// Assumes lps_host on the host lines and lps_chk bound onto the design.
`timescale 1ns/1ns
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  $display("[ERR] %s exp %h got %h", n, e, g); n_errors++; end end
module tb_lps_ctrl;
  import lps_pkg::*;
  localparam int BIT_CYC = 217;           // Baud code 7 bit-time in cycles
  logic          sys_clk, rst_n, clk_en;  // Clock, reset, enable
  logic          reg_wr, reg_rd, ram_ok;  // Strobes and RAM check
  logic [AW-1:0] reg_addr;                // Register index
  logic [DW-1:0] reg_wdata, reg_rdata, rv; // Data and last read
  logic [7:0]    core_v;                  // txd cts pkt exc rssi cmd buf dbg
  logic          rxd_pin, reset_line_pin, config_line_n_pin, txd_w;
  logic          txd_o, txd_oe_n, cts_n_o, packet_processing_output, exception_output;
  logic          rssi_o, command_reply_line_o, command_reply_line_oe_n, buffer_empty_line_o;
  logic          buffer_empty_line_oe_n, debug_data_pin_oe_n, pullup_en_o, radio_tx_en_o;
  logic          radio_rx_en_o, radio_osc_en_o, radio_lowest_o, hop_sync_en_o;
  logic          rx_monitor_en_o, nonessential_en_o, core_run_o;
  logic [1:0]    ctl_clk_sel_o;
  int            n_errors, compares, cyc; // Counters

  // Transmit wire with its pull-up
  assign txd_w = txd_oe_n ? 1'b1 : txd_o;

  lps_ctrl lps_ctrl_i (
    .sys_clk, .rst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rxd_pin,
    .reset_line_pin, .config_line_n_pin, .ram_ok, .core_txd(core_v[7]), .core_cts_n(core_v[6]),
    .core_pkt(core_v[5]), .core_exc(core_v[4]), .core_rssi(core_v[3]),
    .core_cmd_reply(core_v[2]), .core_buf_empty(core_v[1]), .core_debug_oe_n(core_v[0]), .txd_o,
    .txd_oe_n, .cts_n_o, .packet_processing_output, .exception_output, .rssi_o,
    .command_reply_line_o, .command_reply_line_oe_n, .buffer_empty_line_o,
    .buffer_empty_line_oe_n, .debug_data_pin_oe_n, .pullup_en_o, .radio_tx_en_o, .radio_rx_en_o,
    .radio_osc_en_o, .radio_lowest_o, .hop_sync_en_o, .rx_monitor_en_o, .ctl_clk_sel_o,
    .nonessential_en_o, .core_run_o
  );
  lps_host #(.BIT_CYC(BIT_CYC)) lps_host_i (
    .sys_clk(sys_clk), .txd_w(txd_w), .rxd_pin(rxd_pin), .reset_line_pin(reset_line_pin),
    .config_line_n_pin(config_line_n_pin)
  );

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the planned run length
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_errors++;
      results();
    end
  end

  // One register write cycle
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // One register read; data stand only in the following cycle
  task automatic rd(input logic [AW-1:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  endtask : rd

  // Reset held 16 cycles
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // Bounded wait for active operation, far inside 6 ms
  task automatic wait_run(input int lim);
    int k;
    k = 0;
    while (core_run_o !== 1'b1 && k < lim)
    begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    `CHK("awake", 1'b1, core_run_o)
  endtask : wait_run

  // Active pins follow the core
  task automatic act_chk;
    `CHK("active", {2'b10, core_v[6:1], CLK_FULL, 2'b01}, {core_run_o, pullup_en_o, cts_n_o,
      packet_processing_output, exception_output, rssi_o, command_reply_line_o,
      buffer_empty_line_o, ctl_clk_sel_o, radio_lowest_o, nonessential_en_o})
  endtask : act_chk

  // Enter a mode, check parking, wake, check restore
  task automatic lp_cycle(input logic [DW-1:0] m, input bit ack);
    logic [7:0] b;
    logic       s;
    logic       dp;
    dp = (m == MODE_DEEP);
    wr(ADDR_OPMODE, m);
    repeat (6) @(posedge sys_clk);
    #1;
    `CHK("park", {4'h8, dp, m == MODE_STANDBY, dp, dp ? CLK_STOP : CLK_SLOW}, {pullup_en_o,
      packet_processing_output, exception_output, rssi_o, cts_n_o, radio_osc_en_o,
      radio_lowest_o, ctl_clk_sel_o})
    `CHK("radio", 4'h0, {radio_tx_en_o, radio_rx_en_o, hop_sync_en_o, rx_monitor_en_o})
    `CHK("oe", 3'h7, {command_reply_line_oe_n, buffer_empty_line_oe_n, debug_data_pin_oe_n})
    rd(ADDR_STATUS);
    `CHK("lp flag", 1'b1, rv[ST_LP_BIT])
    lps_host_i.pull(dp ? 1 : 0, dp ? 500 : BIT_CYC + 4);
    #1;
    `CHK("held", 2'b01, {core_run_o, pullup_en_o})
    if (ack)
    begin
      lps_host_i.recv(b, s);
      `CHK("ack", {1'b1, ACK_BYTE}, {s, b})
    end
    wait_run(4000);
    act_chk();
  endtask : lp_cycle

  // Counts and verdict
  task results;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  // Main sequence
  initial
  begin
    {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {clk_en, ram_ok} = 2'b11;
    core_v = 8'hBC;
    {n_errors, compares, cyc} = '0;
    do_reset();
    wait_run(200);
    act_chk();
    wr(ADDR_BAUD, 8'h07);
    rd(ADDR_BAUD);
    `CHK("baud", 8'h07, rv)
    rd(3'h7);
    `CHK("unmapped", 8'h00, rv)
    wr(ADDR_OPMODE, 8'h04);
    repeat (4) @(posedge sys_clk);
    #1;
    act_chk();
    lp_cycle(MODE_STANDBY, 1'b0);
    lp_cycle(MODE_SLEEP, 1'b0);
    lp_cycle(MODE_DEEP, 1'b0);
    rd(ADDR_BAUD);
    `CHK("kept", 8'h07, rv)
    wr(ADDR_ACK_EN, 8'h01);
    lp_cycle(MODE_SLEEP, 1'b1);
    wr(ADDR_ACK_EN, 8'h00);
    wr(ADDR_NV_BAUD, 8'h07);
    wr(ADDR_BAUD, 8'h05);
    ram_ok <= 1'b0;
    lp_cycle(MODE_DEEP, 1'b0);
    ram_ok <= 1'b1;
    rd(ADDR_BAUD);
    `CHK("reload", 8'h07, rv)
    rd(ADDR_STATUS);
    `CHK("reinit", 1'b1, rv[ST_REINIT_BIT])
    lps_host_i.cfg(1'b0);
    do_reset();
    repeat (200) @(posedge sys_clk);
    #1;
    `CHK("cfg hold", 1'b0, core_run_o)
    wr(ADDR_NV_BAUD, 8'h07);
    lps_host_i.cfg(1'b1);
    wait_run(200);
    rd(ADDR_NV_BAUD);
    `CHK("factory", BAUD_DEFAULT, rv)
    rd(ADDR_BAUD);
    `CHK("power up", BAUD_DEFAULT, rv)
    results();
  end
endmodule : tb_lps_ctrl
